// ### common/ivtu_defines.vh
`ifndef IVTU_DEFINES_VH
`define IVTU_DEFINES_VH

// node count and layout
`define IVTU_NODES          8
`define IVTU_HW_NODES       4
`define IVTU_TRAPS          8
`define IVTU_STK_DEPTH      4'h8

// node control fields
`define IVTU_LVL_HI         3
`define IVTU_LVL_LO         0
`define IVTU_IE_BIT         6
`define IVTU_IR_BIT         7

// idle level, and the service levels beyond the sixteen interrupt levels
`define IVTU_LVL_IDLE       5'h00
`define IVTU_LVL_TRAP_B     5'h10
`define IVTU_LVL_TRAP_A     5'h11

// trap numbers of the nodes
`define IVTU_TN_CAPREL      7'h27
`define IVTU_TN_ADC_DONE    7'h28
`define IVTU_TN_ADC_OVR     7'h29
`define IVTU_TN_XFER_END    7'h4C
`define IVTU_TN_FREE0       7'h10
`define IVTU_TN_FREE1       7'h11
`define IVTU_TN_FREE2       7'h12
`define IVTU_TN_FREE3       7'h13

// trap numbers of the hardware traps
`define IVTU_TN_NMI         7'h02
`define IVTU_TN_STKOF       7'h04
`define IVTU_TN_STKUF       7'h06
`define IVTU_TN_SOFTBRK     7'h08
`define IVTU_TN_CLASS_B     7'h0A

// vector spacing: shift applied to trap number
`define IVTU_SHIFT_BASE     4'h2

// register byte addresses
`define IVTU_A_NODE0        8'h00
`define IVTU_A_NODE_LAST    8'h1C
`define IVTU_A_VSEG         8'h20
`define IVTU_A_CPUCON       8'h24
`define IVTU_A_TFLAG        8'h28
`define IVTU_A_ISTAT        8'h2C
`define IVTU_A_IMASK        8'h30
`define IVTU_A_SVC          8'h34

// reset values
`define IVTU_RST_VSEG       8'h00
`define IVTU_RST_VSC        2'h0

// interrupt status bits
`define IVTU_EV_TRAP        0
`define IVTU_EV_FULL        1
`define IVTU_EV_UNDER       2
`define IVTU_EV_W           3

`endif

// ### rtl/ivtu_pick.v
`timescale 1ns/1ps
`include "ivtu_defines.vh"

// picks the pending, enabled node with the highest level; lower index wins ties
module ivtu_pick (
  input  wire [`IVTU_NODES-1:0]   req,
  input  wire [`IVTU_NODES-1:0]   en,
  input  wire [4*`IVTU_NODES-1:0] lvl,
  output reg                      found,
  output reg  [2:0]               idx,
  output reg  [3:0]               best
);

  integer i;

  //////////////////////////////////////////////////////////////////////////
  // linear scan, strict compare keeps the lowest index on equal levels
  always @* begin
    found = 1'b0;
    idx   = 3'h0;
    best  = 4'h0;
    for (i = 0; i < `IVTU_NODES; i = i + 1) begin
      if (req[i] && en[i] && (!found || lvl[4*i +: 4] > best)) begin
        found = 1'b1;
        idx   = i[2:0];
        best  = lvl[4*i +: 4];
      end
    end
  end

endmodule

// ### rtl/ivtu_core.v
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ivtu_defines.vh"

module ivtu_core (
  input  wire                      clk,
  input  wire                      rst,
  input  wire                      ce,
  // avalon-mm slave
  input  wire [7:0]                avs_address,
  input  wire                      avs_read,
  input  wire                      avs_write,
  input  wire [31:0]               avs_writedata,
  input  wire [3:0]                avs_byteenable,
  output wire [31:0]               avs_readdata,
  output wire                      avs_waitrequest,
  // request sources
  input  wire [`IVTU_HW_NODES-1:0] node_hw_req,
  input  wire [`IVTU_TRAPS-1:0]    trap_event,
  // cpu side
  output wire                      vec_valid,
  output wire [23:0]               vec_addr,
  output wire [6:0]                vec_trap,
  output wire                      vec_is_trap,
  input  wire                      vec_ack,
  input  wire                      svc_return,
  output wire                      irq
);

  //////////////////////////////////////////////////////////////////////////
  // functions

  // fixed trap number of each node
  function [6:0] node_trap;
    input [2:0] n;
    begin
      case (n)
        3'h0:    node_trap = `IVTU_TN_CAPREL;
        3'h1:    node_trap = `IVTU_TN_ADC_DONE;
        3'h2:    node_trap = `IVTU_TN_ADC_OVR;
        3'h3:    node_trap = `IVTU_TN_XFER_END;
        3'h4:    node_trap = `IVTU_TN_FREE0;
        3'h5:    node_trap = `IVTU_TN_FREE1;
        3'h6:    node_trap = `IVTU_TN_FREE2;
        default: node_trap = `IVTU_TN_FREE3;
      endcase
    end
  endfunction

  // offset inside the segment: trap number times the spacing
  function [15:0] vec_offset;
    input [6:0] tn;
    input [1:0] vsc;
    reg   [3:0] sh;
    begin
      sh         = `IVTU_SHIFT_BASE + {2'h0, vsc};
      vec_offset = {9'h000, tn} << sh;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // state

  reg [7:0]                node_ctl_r [0:`IVTU_NODES-1]; // node control words
  reg [7:0]                vseg_r;       // vector segment
  reg [1:0]                vsc_r;        // spacing field
  reg [`IVTU_TRAPS-1:0]    tflag_r;      // sticky trap flags for software
  reg [`IVTU_TRAPS-1:0]    tpend_r;      // traps awaiting vectoring
  reg [`IVTU_EV_W-1:0]     istat_r;      // interrupt status
  reg [`IVTU_EV_W-1:0]     imask_r;      // interrupt mask
  reg [4:0]                stk_r [0:7];  // levels of nested services
  reg [3:0]                sp_r;         // stack fill
  reg                      ack_r;        // bus answer cycle
  reg [31:0]               rdata_r;      // read data
  reg                      ofr_valid_r;  // registered offer to cpu
  reg [23:0]               ofr_addr_r;
  reg [6:0]                ofr_trap_r;
  reg                      ofr_is_trap_r;
  reg                      ofr_cls_a_r;
  reg [2:0]                ofr_idx_r;    // node or class-a trap index
  reg [4:0]                ofr_lvl_r;

  integer k;   // gather loop
  integer ks;  // stack reset loop
  integer kn;  // node register loop

  //////////////////////////////////////////////////////////////////////////
  // combinational decode

  wire       bus_req  = avs_read | avs_write;
  wire       bus_wr   = ack_r & avs_write & avs_byteenable[0];
  wire       bus_rd   = ack_r & avs_read;
  wire       node_sel = (avs_address <= `IVTU_A_NODE_LAST) && (avs_address[1:0] == 2'h0);
  wire [2:0] node_n   = avs_address[4:2];
  wire       take     = ce & vec_ack & ofr_valid_r;
  wire       ret      = ce & svc_return;
  wire [4:0] cur_lvl  = (sp_r == 4'h0) ? `IVTU_LVL_IDLE : stk_r[sp_r[2:0] - 3'h1];
  wire       stk_full = (sp_r == `IVTU_STK_DEPTH);

  assign avs_waitrequest = bus_req & ~ack_r;
  assign avs_readdata    = rdata_r;
  assign vec_valid       = ofr_valid_r;
  assign vec_addr        = ofr_addr_r;
  assign vec_trap        = ofr_trap_r;
  assign vec_is_trap     = ofr_is_trap_r;
  assign irq             = |(istat_r & imask_r);

  // gather request, enable and level for the picker
  reg [`IVTU_NODES-1:0]   pk_req;
  reg [`IVTU_NODES-1:0]   pk_en;
  reg [4*`IVTU_NODES-1:0] pk_lvl;
  always @* begin
    pk_req = {`IVTU_NODES{1'b0}};
    pk_en  = {`IVTU_NODES{1'b0}};
    pk_lvl = {4*`IVTU_NODES{1'b0}};
    for (k = 0; k < `IVTU_NODES; k = k + 1) begin
      pk_req[k]       = node_ctl_r[k][`IVTU_IR_BIT];
      pk_en[k]        = node_ctl_r[k][`IVTU_IE_BIT];
      pk_lvl[4*k +: 4] = node_ctl_r[k][`IVTU_LVL_HI:`IVTU_LVL_LO];
    end
  end

  wire       pk_found;
  wire [2:0] pk_idx;
  wire [3:0] pk_best;

  ivtu_pick u_pick (
    .req   (pk_req),
    .en    (pk_en),
    .lvl   (pk_lvl),
    .found (pk_found),
    .idx   (pk_idx),
    .best  (pk_best)
  );

  // pick the offer: class a traps, then class b, then nodes
  reg        nx_valid;
  reg [6:0]  nx_trap;
  reg        nx_is_trap;
  reg        nx_cls_a;
  reg [2:0]  nx_idx;
  reg [4:0]  nx_lvl;
  always @* begin
    nx_valid   = 1'b0;
    nx_trap    = 7'h00;
    nx_is_trap = 1'b0;
    nx_cls_a   = 1'b0;
    nx_idx     = 3'h0;
    nx_lvl     = `IVTU_LVL_IDLE;
    if (|tpend_r[3:0]) begin
      nx_is_trap = 1'b1;
      nx_cls_a   = 1'b1;
      nx_lvl     = `IVTU_LVL_TRAP_A;
      if (tpend_r[0]) begin
        nx_trap = `IVTU_TN_NMI;
        nx_idx  = 3'h0;
      end else if (tpend_r[1]) begin
        nx_trap = `IVTU_TN_STKOF;
        nx_idx  = 3'h1;
      end else if (tpend_r[2]) begin
        nx_trap = `IVTU_TN_STKUF;
        nx_idx  = 3'h2;
      end else begin
        nx_trap = `IVTU_TN_SOFTBRK;
        nx_idx  = 3'h3;
      end
    end else if (|tpend_r[7:4]) begin
      // class b traps share one vector
      nx_is_trap = 1'b1;
      nx_lvl     = `IVTU_LVL_TRAP_B;
      nx_trap    = `IVTU_TN_CLASS_B;
    end else if (pk_found) begin
      nx_lvl  = {1'b0, pk_best};
      nx_idx  = pk_idx;
      nx_trap = node_trap(pk_idx);
    end
    // a trap waits only for a full stack or for a trap of its own class or a higher one in service
    // trap levels sit above all sixteen node levels
    if (nx_lvl > cur_lvl)
      nx_valid = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // offer register; dropped for one cycle after take or return so that a
  // stale offer built before the stack moved is never shown twice
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ofr_valid_r   <= 1'b0;
      ofr_addr_r    <= 24'h000000;
      ofr_trap_r    <= 7'h00;
      ofr_is_trap_r <= 1'b0;
      ofr_cls_a_r   <= 1'b0;
      ofr_idx_r     <= 3'h0;
      ofr_lvl_r     <= 5'h00;
    end else if (ce) begin
      ofr_valid_r   <= nx_valid & ~stk_full & ~take & ~ret;
      ofr_addr_r    <= {vseg_r, vec_offset(nx_trap, vsc_r)};
      ofr_trap_r    <= nx_trap;
      ofr_is_trap_r <= nx_is_trap;
      ofr_cls_a_r   <= nx_cls_a;
      ofr_idx_r     <= nx_idx;
      ofr_lvl_r     <= nx_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // service stack: push on take, pop on return
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_r <= 4'h0;
      for (ks = 0; ks < 8; ks = ks + 1)
        stk_r[ks] <= 5'h00;
    end else if (ce) begin
      if (take) begin
        stk_r[sp_r[2:0]] <= ofr_lvl_r;
        sp_r             <= sp_r + 4'h1;
      end else if (ret && sp_r != 4'h0) begin
        sp_r <= sp_r - 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // traps: pending bits and software-visible flags
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tpend_r <= {`IVTU_TRAPS{1'b0}};
      tflag_r <= {`IVTU_TRAPS{1'b0}};
    end else if (ce) begin
      // pending cleared on take, new event wins
      if (take && ofr_is_trap_r) begin
        if (ofr_cls_a_r)
          tpend_r <= (tpend_r & ~({{`IVTU_TRAPS-1{1'b0}}, 1'b1} << ofr_idx_r)) | trap_event;
        else
          tpend_r <= {4'h0, tpend_r[3:0]} | trap_event;
      end else begin
        tpend_r <= tpend_r | trap_event;
      end
      // write one to clear, set wins
      if (bus_wr && avs_address == `IVTU_A_TFLAG)
        tflag_r <= (tflag_r & ~avs_writedata[`IVTU_TRAPS-1:0]) | trap_event;
      else
        tflag_r <= tflag_r | trap_event;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // node control registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (kn = 0; kn < `IVTU_NODES; kn = kn + 1)
        node_ctl_r[kn] <= 8'h00;
    end else if (ce) begin
      for (kn = 0; kn < `IVTU_NODES; kn = kn + 1) begin
        // software writes request, enable and level
        if (bus_wr && node_sel && node_n == kn[2:0])
          node_ctl_r[kn] <= avs_writedata[7:0] & 8'hCF;
        // request cleared when the cpu takes the node
        else if (take && !ofr_is_trap_r && ofr_idx_r == kn[2:0])
          node_ctl_r[kn][`IVTU_IR_BIT] <= 1'b0;
        // only low nodes have a hardware line; set wins
        if (kn < `IVTU_HW_NODES) begin
          if (node_hw_req[kn])
            node_ctl_r[kn][`IVTU_IR_BIT] <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration, mask, interrupt status
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      vseg_r  <= `IVTU_RST_VSEG;
      vsc_r   <= `IVTU_RST_VSC;
      imask_r <= {`IVTU_EV_W{1'b0}};
      istat_r <= {`IVTU_EV_W{1'b0}};
    end else if (ce) begin
      if (bus_wr && avs_address == `IVTU_A_VSEG)
        vseg_r <= avs_writedata[7:0];
      if (bus_wr && avs_address == `IVTU_A_CPUCON)
        vsc_r <= avs_writedata[1:0];
      if (bus_wr && avs_address == `IVTU_A_IMASK)
        imask_r <= avs_writedata[`IVTU_EV_W-1:0];
      // read clears, events in the same cycle survive
      istat_r <= ((bus_rd && avs_address == `IVTU_A_ISTAT) ? {`IVTU_EV_W{1'b0}} : istat_r)
               | {ret && sp_r == 4'h0, nx_valid && stk_full, |trap_event};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bus: one wait cycle, data registered for the answer cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else if (ce) begin
      ack_r   <= bus_req & ~ack_r;
      rdata_r <= 32'h00000000;
      if (avs_read && !ack_r) begin
        if (node_sel)
          rdata_r <= {24'h000000, node_ctl_r[node_n]};
        else begin
          case (avs_address)
            `IVTU_A_VSEG:   rdata_r <= {24'h000000, vseg_r};
            `IVTU_A_CPUCON: rdata_r <= {30'h00000000, vsc_r};
            `IVTU_A_TFLAG:  rdata_r <= {24'h000000, tflag_r};
            `IVTU_A_ISTAT:  rdata_r <= {29'h00000000, istat_r};
            `IVTU_A_IMASK:  rdata_r <= {29'h00000000, imask_r};
            `IVTU_A_SVC:    rdata_r <= {19'h00000, cur_lvl, 4'h0, sp_r};
            default:        rdata_r <= 32'h00000000;
          endcase
        end
      end
    end
  end

endmodule

// ### dv/ivtu_core_asserts.sv
`timescale 1ns/1ps
// watches the core ports; mirrors the few registers it needs
module ivtu_core_chk (
  input wire        clk,
  input wire        rst,
  input wire        ce,
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [7:0]  trap_event,
  input wire        vec_valid,
  input wire [23:0] vec_addr,
  input wire [6:0]  vec_trap,
  input wire        vec_is_trap,
  input wire        vec_ack,
  input wire        svc_return,
  input wire        irq
);
  wire       wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0];
  reg  [7:0] seg_r; // mirrored segment
  reg  [1:0] vsc_r; // mirrored spacing field
  reg  [2:0] msk_r; // mirrored irq mask
  reg  [3:0] dep_r; // services taken and not returned
  reg        trp_r; // innermost service is a trap (weak after nesting)
  // mirror writes and stack moves
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      seg_r <= 8'h00;
      vsc_r <= 2'h0;
      msk_r <= 3'h0;
      dep_r <= 4'h0;
      trp_r <= 1'b0;
    end else if (ce) begin
      if (wr_ok && avs_address == 8'h20) seg_r <= avs_writedata[7:0];
      if (wr_ok && avs_address == 8'h24) vsc_r <= avs_writedata[1:0];
      if (wr_ok && avs_address == 8'h30) msk_r <= avs_writedata[2:0];
      if (vec_valid && vec_ack) begin
        dep_r <= dep_r + 4'h1;
        trp_r <= vec_is_trap;
      end else if (svc_return) begin
        dep_r <= (dep_r == 4'h0) ? 4'h0 : dep_r - 4'h1;
        trp_r <= 1'b0;
      end
    end
  end
  // a frozen clock enable stretches everything, so it aborts checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);
  ////////////////////////////////////////////////////////////////////
  property p_wait; $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not after one wait");
  property p_rdz; !(avs_read && !avs_waitrequest) |-> avs_readdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside answer");
  property p_addr; vec_valid && vsc_r == $past(vsc_r, 2) && seg_r == $past(seg_r, 2)
    |-> vec_addr == {seg_r, ({9'h000, vec_trap} << (2 + vsc_r))}; endproperty
  a_addr: assert property (p_addr) else $error("vector address wrong");
  property p_nmi; trap_event[0] && dep_r == 4'h0
    |-> ##[1:4] (vec_valid && vec_is_trap && vec_trap == 7'h02); endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not offered");
  property p_gap; vec_valid && vec_ack |=> !vec_valid; endproperty
  a_gap: assert property (p_gap) else $error("offer stands after ack");
  property p_tnum; vec_valid && vec_is_trap
    |-> vec_trap inside {7'h02, 7'h04, 7'h06, 7'h08, 7'h0A}; endproperty
  a_tnum: assert property (p_tnum) else $error("bad trap number");
  property p_nnum; vec_valid && !vec_is_trap
    |-> vec_trap inside {7'h27, 7'h28, 7'h29, 7'h4C, [7'h10:7'h13]}; endproperty
  a_nnum: assert property (p_nnum) else $error("bad node number");
  property p_block; trp_r |-> !(vec_valid && !vec_is_trap); endproperty
  a_block: assert property (p_block) else $error("node offered in trap");
  property p_irq; msk_r == 3'h0 |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq while masked");
endmodule
bind ivtu_core ivtu_core_chk u_chk (.clk(clk), .rst(rst), .ce(ce),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .trap_event(trap_event), .vec_valid(vec_valid), .vec_addr(vec_addr),
  .vec_trap(vec_trap), .vec_is_trap(vec_is_trap), .vec_ack(vec_ack),
  .svc_return(svc_return), .irq(irq));

// ### dv/ivtu_cpu_model.sv
`timescale 1ns/1ps
// cpu stand-in: takes each offer after a chosen wait and logs it
module ivtu_cpu_model (
  input  wire        clk,
  input  wire        rst,
  input  wire        ack_on,
  input  wire [1:0]  dly,
  input  wire        vec_valid,
  input  wire [23:0] vec_addr,
  input  wire [6:0]  vec_trap,
  input  wire        vec_is_trap,
  output reg         vec_ack,
  output reg  [23:0] got_addr,
  output reg  [6:0]  got_trap,
  output reg         got_is_trap,
  output reg  [7:0]  acks
);
  reg [1:0] cnt_r; // cycles the offer has waited
  // one-cycle ack; a vanished offer just loses it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      vec_ack <= 1'b0;
      cnt_r <= 2'h0;
      acks <= 8'h00;
      got_addr <= 24'h0;
      got_trap <= 7'h0;
      got_is_trap <= 1'b0;
    end else begin
      // ack an offer that has waited dly cycles; one assignment per edge
      vec_ack <= ack_on && vec_valid && !vec_ack && cnt_r == dly;
      if (vec_ack && vec_valid) begin
        acks <= acks + 8'h01;
        got_addr <= vec_addr;
        got_trap <= vec_trap;
        got_is_trap <= vec_is_trap;
        cnt_r <= 2'h0;
      end else if (ack_on && vec_valid && !vec_ack && cnt_r != dly) begin
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end
endmodule

// ### dv/interrupt_vector_and_trap_unit_tb.sv
`timescale 1ns/1ps
module interrupt_vector_and_trap_unit_tb;
  reg clk, rst, ce, avs_read, avs_write, svc_return, ack_on;
  reg [7:0] avs_address, trap_event, seg;
  reg [31:0] avs_writedata, rd;
  reg [3:0] avs_byteenable, node_hw_req, lv;
  reg [1:0] dly;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, vec_valid, vec_is_trap, vec_ack, irq, got_is_trap;
  wire [23:0] vec_addr, got_addr;
  wire [6:0] vec_trap, got_trap;
  wire [7:0] acks;
  integer failures, samples_checked, cyc, i;
  reg [6:0] tn [0:7];
  ivtu_core dut (.clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .node_hw_req(node_hw_req),
    .trap_event(trap_event), .vec_valid(vec_valid), .vec_addr(vec_addr),
    .vec_trap(vec_trap), .vec_is_trap(vec_is_trap), .vec_ack(vec_ack),
    .svc_return(svc_return), .irq(irq));
  ivtu_cpu_model cpu (.clk(clk), .rst(rst), .ack_on(ack_on), .dly(dly),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_trap(vec_trap),
    .vec_is_trap(vec_is_trap), .vec_ack(vec_ack), .got_addr(got_addr),
    .got_trap(got_trap), .got_is_trap(got_is_trap), .acks(acks));
  ////////////////////////////////////////////////////////////////////
  // expected vector: segment on top, scaled trap number below
  function [23:0] vaddr(input [7:0] s, input [6:0] t, input [1:0] f);
    vaddr = {s, ({9'h000, t} << (2 + f))};
  endfunction
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // avalon cycle: request held until waitrequest is seen low at a rising
  // edge; read data taken at that same edge, release only after it
  task bus(input w, input [7:0] a, input [31:0] d);
    reg wt;
    wt = 1'b1;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    while (wt) begin
      @(posedge clk);
      wt = (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rchk(input [7:0] a, input [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task pulse(input [3:0] hw, input [7:0] tr);
    @(posedge clk);
    node_hw_req <= hw;
    trap_event <= tr;
    @(posedge clk);
    node_hw_req <= 4'h0;
    trap_event <= 8'h00;
  endtask
  task ret;
    @(posedge clk);
    svc_return <= 1'b1;
    @(posedge clk);
    svc_return <= 1'b0;
  endtask
  // wait for the cpu model to take an offer, bounded
  task take(input [6:0] t, input it, input [23:0] ad);
    reg [7:0] a0;
    integer n;
    a0 = acks;
    for (n = 0; n < 40 && acks == a0; n = n + 1) @(posedge clk);
    chk("taken", acks, a0 + 8'h01);
    chk("trap", got_trap, t);
    chk("kind", got_is_trap, it);
    chk("addr", got_addr, ad);
  endtask
  task none;
    reg [7:0] a0;
    a0 = acks;
    repeat (20) @(posedge clk);
    chk("no offer", acks, a0);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures = failures + 1;
      close_out;
    end
  end
  initial begin
    {rst, ce, ack_on} = 3'b111;
    {avs_read, avs_write, svc_return, dly} = 5'h00;
    {avs_address, trap_event, node_hw_req} = 20'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    {failures, samples_checked, cyc} = 96'h0;
    tn = '{7'h27, 7'h28, 7'h29, 7'h4C, 7'h10, 7'h11, 7'h12, 7'h13};
    void'($urandom(59));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h20, 32'h0, "seg reset");
    rchk(8'h24, 32'h0, "vsc reset");
    rchk(8'h3C, 32'h0, "unmapped");
    avs_byteenable <= 4'h0;
    bus(1'b1, 8'h20, 32'hAA);
    avs_byteenable <= 4'hF;
    rchk(8'h20, 32'h0, "no lane");
    // every node, every spacing, random segment and level
    for (i = 0; i < 8; i = i + 1) begin
      seg = 8'($urandom);
      lv = 4'($urandom_range(15, 1));
      bus(1'b1, 8'h20, {24'h0, seg});
      bus(1'b1, 8'h24, 32'(i % 4));
      if (i < 4) bus(1'b1, 8'(i * 4), {28'h4, lv});
      else bus(1'b1, 8'(i * 4), {28'hC, lv});
      if (i < 4) pulse(4'(1 << i), 8'h00);
      take(tn[i], 1'b0, vaddr(seg, tn[i], 2'(i % 4)));
      rchk(8'(i * 4), {28'h4, lv}, "node ctl");
      ret;
    end
    // traps: nmi, then class b and a node queued behind it
    bus(1'b1, 8'h24, 32'h0);
    bus(1'b1, 8'h30, 32'h1);
    pulse(4'h0, 8'h01);
    take(7'h02, 1'b1, vaddr(seg, 7'h02, 2'h0));
    chk("irq", irq, 1);
    bus(1'b1, 8'h10, 32'hCF);
    pulse(4'h0, 8'h10);
    none;
    rchk(8'h2C, 32'h1, "status");
    @(negedge clk);
    chk("irq off", irq, 0);
    ret;
    take(7'h0A, 1'b1, vaddr(seg, 7'h0A, 2'h0));
    rchk(8'h28, 32'h11, "flags");
    bus(1'b1, 8'h28, 32'hFF);
    rchk(8'h28, 32'h0, "flags clr");
    ret;
    take(7'h10, 1'b0, vaddr(seg, 7'h10, 2'h0));
    ret;
    // slow cpu; equal level waits, higher level preempts
    dly <= 2'h3;
    bus(1'b1, 8'h00, 32'h45);
    pulse(4'h1, 8'h00);
    take(7'h27, 1'b0, vaddr(seg, 7'h27, 2'h0));
    bus(1'b1, 8'h04, 32'hC5);
    none;
    bus(1'b1, 8'h08, 32'hC6);
    take(7'h29, 1'b0, vaddr(seg, 7'h29, 2'h0));
    rchk(8'h34, 32'h602, "svc level depth");
    ret;
    ret;
    take(7'h28, 1'b0, vaddr(seg, 7'h28, 2'h0));
    ret;
    // return with nothing in service raises status bit two
    ret;
    rchk(8'h2C, 32'h4, "empty ret");
    // frozen clock enable drops a trap event
    ce <= 1'b0;
    pulse(4'h0, 8'h02);
    @(posedge clk);
    ce <= 1'b1;
    rchk(8'h28, 32'h0, "frozen");
    close_out;
  end
endmodule
